//--- common/idc_pkg.sv
// Constants shared by the IDE decode and reset control block.
// Assumes byte addresses of 32-bit Wishbone words, four bytes per index.
package idc_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_PROG_IF = 8'h09;
  localparam logic [7:0] IDX_DECODE_CTRL = 8'h50;
  localparam logic [7:0] IDX_RESET_TEST = 8'h51;
  // Decode and function control fields
  localparam int DEC_THIRD_BYTE_BIT = 5;
  localparam int DEC_PORT_BE_BIT = 3;
  localparam int DEC_PROG_IF_REPORT_BIT = 1;
  localparam int DEC_FUNC_ENABLE_BIT = 0;
  localparam logic [7:0] DEC_WRITABLE_MASK = 8'h2b;
  localparam logic [7:0] DEC_RESET = 8'h02;
  // Reset and test control fields
  localparam int RT_CHIP_RESET_BIT = 7;
  localparam int RT_SOFT_RESET_BIT = 6;
  localparam int RT_CH2_RESET_BIT = 5;
  localparam int RT_CH1_RESET_BIT = 4;
  localparam int RT_AUTOPOLL_TEST_BIT = 2;
  localparam int RT_LATENCY_TEST_BIT = 1;
  localparam int RT_FIFO_TEST_BIT = 0;
  localparam logic [7:0] RT_PULSE_MASK = 8'hf0;
  localparam logic [7:0] RT_MODE_MASK = 8'h07;
  localparam logic [7:0] RT_RESET = 8'h00;
  // Programming interface field, bits 6 to 4 of its byte
  localparam int PI_LSB = 4;
  localparam int PI_W = 3;
  localparam logic [2:0] PI_RESET = 3'h0;
  localparam logic [2:0] PI_MASKED = 3'h0;
  // Legacy control ports, dword address and byte lane
  localparam logic [15:0] PORT_PRIMARY_CTRL = 16'h03f6;
  localparam logic [15:0] PORT_SECONDARY_CTRL = 16'h0376;
  localparam int PORT_LANE = 2;
  localparam int WINDOW_LANE = 2;
  // Bus answer states
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } idc_bus_state_t;
endpackage : idc_pkg

//--- hw/idc_pulse_gen.sv
// One-cycle pulse generator for write-one-to-pulse control bits.
// Assumes the write strobe lasts one clock and data is stable with it.
`timescale 1ns/1ps
`default_nettype none
module idc_pulse_gen #(
  parameter int WIDTH = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic write_strobe,
  input wire logic [WIDTH-1:0] write_data,
  output logic [WIDTH-1:0] pulse
);

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("Pulse width must be at least one");
    end
  endgenerate

  // Each written one raises its pulse for exactly one clock
  always_ff @(posedge clk) begin
    if (srst) begin
      pulse <= '0;
    end else if (write_strobe) begin
      pulse <= write_data;
    end else begin
      pulse <= '0;
    end
  end

endmodule : idc_pulse_gen
`default_nettype wire

//--- hw/idc_ctrl.sv
// IDE decode control, function enable and test reset register bank.
// Assumes a classic Wishbone master on CLK and I/O cycle info on CLK.
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1: Third-byte bit limits window claims to lane two
// RULE2: Port-decode bit qualifies control ports on lane two
// RULE3: Reporting bit clear masks programming interface to zero
// RULE4: Software keeps reporting bit set normally
// RULE5: Function enable resets off; disabled claims nothing; code still claims while ALT_FUNCTION_ENABLE is high
// RULE6: Chip reset bit pulses whole device reset
// RULE7: Soft reset pulses all but configuration
// RULE8: Channel two reset pulses transfer and poll machines
// RULE9: Channel one reset pulses transfer and poll machines
// RULE10: Autopoll test enable resets off, set enables
// RULE11: Latency timer test enable resets off, set enables
// RULE12: Buffer test enable resets off, set enables
// RULE13: Test register left alone normally, resets zero
// RULE14: Reserved and pulse bits read zero
module idc_ctrl #(
  parameter int ADDR_W = 12
) (
  input wire logic CLK,
  input wire logic SRST,
  // Classic Wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [ADDR_W-1:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // I/O cycle seen on the host bus
  input wire logic IO_CYCLE_VALID,
  input wire logic [15:0] IO_ADDR,
  input wire logic [3:0] BYTE_ENABLE_LANES_N,
  input wire logic NATIVE_MODE,
  input wire logic SECOND_BASE_WINDOW_HIT,
  input wire logic FOURTH_BASE_WINDOW_HIT,
  input wire logic ALT_FUNCTION_ENABLE,
  // Decode results
  output logic IDE_CYCLE_CLAIM,
  output logic FUNCTION_VISIBLE,
  output logic [2:0] PROG_IF_READ_VALUE,
  // Reset pulses and test modes
  output logic WHOLE_DEVICE_RESET_PULSE,
  output logic NONCONFIG_BLOCKS_RESET_PULSE,
  output logic CHANNEL_TWO_ENGINE_RESET,
  output logic CHANNEL_ONE_ENGINE_RESET,
  output logic DRIVE_TRANSFER_FSM_RESET,
  output logic CHANNEL_ONE_PIO_POLL_FSM_RESET,
  output logic CHANNEL_TWO_PIO_POLL_FSM_RESET,
  output logic AUTOPOLL_TEST_ENABLE,
  output logic LATENCY_TIMER_TEST_ENABLE,
  output logic FIFO_TEST_ENABLE
);

  generate
    if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr
      $error("ADDR_W must be 10 to 32 to reach every register");
    end
  endgenerate

  // Word index of a byte address
  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
    logic [31:0] wide;
    wide = 32'(a);
    word_index = wide[9:2];
  endfunction : word_index

  // Above-index bits must be zero for a register hit
  function automatic logic upper_clear(input logic [ADDR_W-1:0] a);
    logic [31:0] wide;
    wide = 32'(a);
    upper_clear = (wide[31:10] == 22'h0) && (wide[1:0] == 2'h0);
  endfunction : upper_clear

  // Control port match, with optional byte enable qualification
  function automatic logic port_match(
    input logic [15:0] addr,
    input logic [15:0] port,
    input logic [3:0] be_n,
    input logic use_be
  );
    logic addr_ok;
    addr_ok = (addr[15:2] == port[15:2]);
    port_match = addr_ok && (!use_be || !be_n[idc_pkg::PORT_LANE]);
  endfunction : port_match

  logic [7:0] decode_and_function_control;
  logic [7:0] reset_and_test_control;
  logic [2:0] prog_if_stored;
  logic internal_reset;
  logic wb_req;
  logic wr_fire;
  logic [7:0] req_index;
  logic req_mapped;
  logic hit_decode;
  logic hit_reset_test;
  logic hit_prog_if;
  logic [3:0] pulse_out;
  logic [3:0] pulse_req;
  logic pulse_wr;
  logic function_enabled;
  logic window_claim;
  logic port_claim;
  logic next_claim;
  logic [7:0] rd_byte;
  logic [2:0] prog_if_view;
  idc_pkg::idc_bus_state_t bus_state;
  idc_pkg::idc_bus_state_t next_bus_state;

  // A chip reset pulse clears this bank like a hardware reset
  assign internal_reset = SRST || WHOLE_DEVICE_RESET_PULSE; // RULE6

  // Request decode
  assign wb_req = CYC_I && STB_I;
  assign req_index = word_index(ADR_I);
  assign hit_decode = upper_clear(ADR_I)
    && (req_index == idc_pkg::IDX_DECODE_CTRL);
  assign hit_reset_test = upper_clear(ADR_I)
    && (req_index == idc_pkg::IDX_RESET_TEST);
  assign hit_prog_if = upper_clear(ADR_I)
    && (req_index == idc_pkg::IDX_PROG_IF);
  assign req_mapped = hit_decode || hit_reset_test || hit_prog_if;

  // Writes take effect on the edge where the master sees ack
  assign wr_fire = wb_req && WE_I && ACK_O && SEL_I[0];

  // Bus answer sequencing
  always_comb begin
    next_bus_state = bus_state;
    case (bus_state)
      idc_pkg::BUS_IDLE: begin
        if (wb_req) begin
          next_bus_state = idc_pkg::BUS_ACK;
        end
      end
      idc_pkg::BUS_ACK: begin
        next_bus_state = idc_pkg::BUS_IDLE;
      end
      default: begin
        next_bus_state = idc_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      bus_state <= idc_pkg::BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  assign ACK_O = (bus_state == idc_pkg::BUS_ACK);

  // Decode and function control register
  always_ff @(posedge CLK) begin
    if (internal_reset) begin
      decode_and_function_control <= idc_pkg::DEC_RESET; // RULE5
    end else if (wr_fire && hit_decode) begin
      decode_and_function_control <=
        DAT_I[7:0] & idc_pkg::DEC_WRITABLE_MASK; // RULE14
    end
  end

  // Test mode bits; pulse bits are never stored
  always_ff @(posedge CLK) begin
    if (internal_reset) begin
      reset_and_test_control <= idc_pkg::RT_RESET; // RULE13
    end else if (wr_fire && hit_reset_test) begin
      reset_and_test_control <=
        DAT_I[7:0] & idc_pkg::RT_MODE_MASK; // RULE14
    end
  end

  // Stored programming interface field
  always_ff @(posedge CLK) begin
    if (internal_reset) begin
      prog_if_stored <= idc_pkg::PI_RESET;
    end else if (wr_fire && hit_prog_if) begin
      prog_if_stored <=
        DAT_I[idc_pkg::PI_LSB +: idc_pkg::PI_W];
    end
  end

  // Reporting bit masks the field on read
  assign prog_if_view =
    decode_and_function_control[idc_pkg::DEC_PROG_IF_REPORT_BIT]
    ? prog_if_stored : idc_pkg::PI_MASKED; // RULE3

  // Read data, latched with the answer
  always_comb begin
    rd_byte = 8'h00;
    if (hit_decode) begin
      rd_byte = decode_and_function_control;
    end else if (hit_reset_test) begin
      rd_byte = reset_and_test_control; // RULE14
    end else if (hit_prog_if) begin
      rd_byte[idc_pkg::PI_LSB +: idc_pkg::PI_W] = prog_if_view;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      DAT_O <= 32'h0000_0000;
    end else if (wb_req && !ACK_O && !WE_I && req_mapped) begin
      DAT_O <= {24'h00_0000, rd_byte};
    end else if (wb_req && !ACK_O) begin
      DAT_O <= 32'h0000_0000;
    end
  end

  // Write-one reset pulses, one clock each
  assign pulse_wr = wr_fire && hit_reset_test;
  assign pulse_req = DAT_I[idc_pkg::RT_CH1_RESET_BIT +: 4];

  idc_pulse_gen #(
    .WIDTH(4)
  ) idc_pulse_gen_i (
    .clk(CLK),
    .srst(SRST),
    .write_strobe(pulse_wr),
    .write_data(pulse_req),
    .pulse(pulse_out)
  );

  assign WHOLE_DEVICE_RESET_PULSE = pulse_out[3]; // RULE6
  assign NONCONFIG_BLOCKS_RESET_PULSE = pulse_out[2]; // RULE7
  assign CHANNEL_TWO_ENGINE_RESET = pulse_out[1]; // RULE8
  assign CHANNEL_ONE_ENGINE_RESET = pulse_out[0]; // RULE9

  // Machine resets; soft and chip resets reach every machine, but not the channel engine reset outputs
  assign DRIVE_TRANSFER_FSM_RESET = |pulse_out; // RULE8 RULE9
  assign CHANNEL_TWO_PIO_POLL_FSM_RESET =
    pulse_out[1] || pulse_out[2] || pulse_out[3]; // RULE8
  assign CHANNEL_ONE_PIO_POLL_FSM_RESET =
    pulse_out[0] || pulse_out[2] || pulse_out[3]; // RULE9

  // Test mode enables
  assign AUTOPOLL_TEST_ENABLE =
    reset_and_test_control[idc_pkg::RT_AUTOPOLL_TEST_BIT]; // RULE10
  assign LATENCY_TIMER_TEST_ENABLE =
    reset_and_test_control[idc_pkg::RT_LATENCY_TEST_BIT]; // RULE11
  assign FIFO_TEST_ENABLE =
    reset_and_test_control[idc_pkg::RT_FIFO_TEST_BIT]; // RULE12

  // Function visibility; either enable bit turns it on
  assign function_enabled =
    decode_and_function_control[idc_pkg::DEC_FUNC_ENABLE_BIT]
    || ALT_FUNCTION_ENABLE; // RULE5

  // Native window claims, optionally third byte only
  always_comb begin
    window_claim = 1'b0;
    if (NATIVE_MODE
        && (SECOND_BASE_WINDOW_HIT || FOURTH_BASE_WINDOW_HIT)) begin
      if (decode_and_function_control[idc_pkg::DEC_THIRD_BYTE_BIT]) begin
        window_claim = !BYTE_ENABLE_LANES_N[idc_pkg::WINDOW_LANE]; // RULE1
      end else begin
        window_claim = 1'b1; // RULE1
      end
    end
  end

  // Legacy control port claims
  always_comb begin
    port_claim = 1'b0;
    if (port_match(IO_ADDR, idc_pkg::PORT_PRIMARY_CTRL,
        BYTE_ENABLE_LANES_N,
        decode_and_function_control[idc_pkg::DEC_PORT_BE_BIT])) begin
      port_claim = 1'b1; // RULE2
    end
    if (port_match(IO_ADDR, idc_pkg::PORT_SECONDARY_CTRL,
        BYTE_ENABLE_LANES_N,
        decode_and_function_control[idc_pkg::DEC_PORT_BE_BIT])) begin
      port_claim = 1'b1; // RULE2
    end
  end

  assign next_claim = IO_CYCLE_VALID && function_enabled
    && (window_claim || port_claim); // RULE5

  always_ff @(posedge CLK) begin
    if (internal_reset) begin
      IDE_CYCLE_CLAIM <= 1'b0;
    end else begin
      IDE_CYCLE_CLAIM <= next_claim;
    end
  end

  always_ff @(posedge CLK) begin
    if (internal_reset) begin
      FUNCTION_VISIBLE <= 1'b0;
    end else begin
      FUNCTION_VISIBLE <= function_enabled; // RULE5
    end
  end

  always_ff @(posedge CLK) begin
    if (internal_reset) begin
      PROG_IF_READ_VALUE <= idc_pkg::PI_MASKED;
    end else begin
      PROG_IF_READ_VALUE <= prog_if_view; // RULE3
    end
  end

endmodule : idc_ctrl
`default_nettype wire

//--- tb/idc_ctrl_asserts.sv
// Checker for idc_ctrl bus answers, decode and reset pulses.
// Assumes it is bound to idc_ctrl and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module idc_ctrl_asserts #(
  parameter int ADDR_W = 12
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [ADDR_W-1:0] ADR_I,
  input wire logic [31:0] DAT_I,
  input wire logic ACK_O,
  input wire logic IO_CYCLE_VALID,
  input wire logic IDE_CYCLE_CLAIM,
  input wire logic WHOLE_DEVICE_RESET_PULSE,
  input wire logic NONCONFIG_BLOCKS_RESET_PULSE,
  input wire logic CHANNEL_TWO_ENGINE_RESET,
  input wire logic CHANNEL_ONE_ENGINE_RESET,
  input wire logic DRIVE_TRANSFER_FSM_RESET,
  input wire logic CHANNEL_ONE_PIO_POLL_FSM_RESET,
  input wire logic CHANNEL_TWO_PIO_POLL_FSM_RESET
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  ack_on_request_a:
    assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("no ack");
  ack_one_cycle_a:
    assert property (ACK_O |=> !ACK_O) else $error("ack held");
  idle_no_claim_a:
    assert property (!$past(IO_CYCLE_VALID) |-> !IDE_CYCLE_CLAIM)
    else $error("claim without cycle");
  chip_pulse_cause_a:
    assert property ($rose(WHOLE_DEVICE_RESET_PULSE) |->
      $past(ACK_O) && $past(WE_I)
      && $past(DAT_I[idc_pkg::RT_CHIP_RESET_BIT])
      && $past(ADR_I[9:2]) == idc_pkg::IDX_RESET_TEST)
    else $error("chip pulse without write");
  chip_pulse_width_a:
    assert property (WHOLE_DEVICE_RESET_PULSE |->
      DRIVE_TRANSFER_FSM_RESET ##1 !WHOLE_DEVICE_RESET_PULSE)
    else $error("chip pulse wrong");
  soft_pulse_width_a:
    assert property (NONCONFIG_BLOCKS_RESET_PULSE |->
      CHANNEL_ONE_PIO_POLL_FSM_RESET && CHANNEL_TWO_PIO_POLL_FSM_RESET
      ##1 !NONCONFIG_BLOCKS_RESET_PULSE)
    else $error("soft pulse wrong");
  ch_two_pulse_a:
    assert property (CHANNEL_TWO_ENGINE_RESET |-> DRIVE_TRANSFER_FSM_RESET
      && CHANNEL_TWO_PIO_POLL_FSM_RESET ##1 !CHANNEL_TWO_ENGINE_RESET)
    else $error("channel two pulse wrong");
  ch_one_pulse_a:
    assert property (CHANNEL_ONE_ENGINE_RESET |-> DRIVE_TRANSFER_FSM_RESET
      && CHANNEL_ONE_PIO_POLL_FSM_RESET ##1 !CHANNEL_ONE_ENGINE_RESET)
    else $error("channel one pulse wrong");
  cover property (ACK_O && WE_I);
  cover property (IDE_CYCLE_CLAIM);
  cover property (WHOLE_DEVICE_RESET_PULSE);
endmodule : idc_ctrl_asserts
bind idc_ctrl idc_ctrl_asserts #(.ADDR_W(ADDR_W)) idc_ctrl_asserts_i (
  .CLK(CLK), .SRST(SRST), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
  .ADR_I(ADR_I), .DAT_I(DAT_I), .ACK_O(ACK_O),
  .IO_CYCLE_VALID(IO_CYCLE_VALID), .IDE_CYCLE_CLAIM(IDE_CYCLE_CLAIM),
  .WHOLE_DEVICE_RESET_PULSE(WHOLE_DEVICE_RESET_PULSE),
  .NONCONFIG_BLOCKS_RESET_PULSE(NONCONFIG_BLOCKS_RESET_PULSE),
  .CHANNEL_TWO_ENGINE_RESET(CHANNEL_TWO_ENGINE_RESET),
  .CHANNEL_ONE_ENGINE_RESET(CHANNEL_ONE_ENGINE_RESET),
  .DRIVE_TRANSFER_FSM_RESET(DRIVE_TRANSFER_FSM_RESET),
  .CHANNEL_ONE_PIO_POLL_FSM_RESET(CHANNEL_ONE_PIO_POLL_FSM_RESET),
  .CHANNEL_TWO_PIO_POLL_FSM_RESET(CHANNEL_TWO_PIO_POLL_FSM_RESET));
`default_nettype wire

//--- tb/idc_io_host.sv
// Host-side model presenting I/O cycles to the decode logic.
// Assumes each call starts just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module idc_io_host (
  input wire logic clk,
  output logic valid,
  output logic [15:0] addr,
  output logic [3:0] be_n
);
  initial begin
    valid = 1'b0;
    addr = 16'h0000;
    be_n = 4'hf;
  end
  // One cycle per call, then released lines show inverted values
  task automatic send(input logic [15:0] a, input logic [3:0] b);
    valid <= 1'b1;
    addr <= a;
    be_n <= b;
    @(posedge clk);
    valid <= 1'b0;
    addr <= ~a;
    be_n <= ~b;
  endtask : send
endmodule : idc_io_host
`default_nettype wire

//--- tb/test_ide_decode_and_reset_control.sv
// Self-checking bench for idc_ctrl over Wishbone and host I/O cycles.
// Assumes idc_io_host stands in for the host's I/O cycles.
`timescale 1ns/1ps
`default_nettype none
module test_ide_decode_and_reset_control;
  logic CLK, SRST, CYC_I, STB_I, WE_I, ACK_O;
  logic [11:0] ADR_I;
  logic [3:0] SEL_I, BYTE_ENABLE_LANES_N;
  logic [31:0] DAT_I, DAT_O, rdata;
  logic IO_CYCLE_VALID, NATIVE_MODE, ALT_FUNCTION_ENABLE;
  logic [15:0] IO_ADDR;
  logic SECOND_BASE_WINDOW_HIT, FOURTH_BASE_WINDOW_HIT;
  logic IDE_CYCLE_CLAIM, FUNCTION_VISIBLE;
  logic [2:0] PROG_IF_READ_VALUE;
  logic WHOLE_DEVICE_RESET_PULSE, NONCONFIG_BLOCKS_RESET_PULSE;
  logic CHANNEL_TWO_ENGINE_RESET, CHANNEL_ONE_ENGINE_RESET;
  logic DRIVE_TRANSFER_FSM_RESET, CHANNEL_ONE_PIO_POLL_FSM_RESET;
  logic CHANNEL_TWO_PIO_POLL_FSM_RESET, AUTOPOLL_TEST_ENABLE;
  logic LATENCY_TIMER_TEST_ENABLE, FIFO_TEST_ENABLE;
  logic [6:0] exp_p;
  int n_errors = 0, n_checks = 0, cycles = 0;
  wire [6:0] pulses = {WHOLE_DEVICE_RESET_PULSE,
    NONCONFIG_BLOCKS_RESET_PULSE, CHANNEL_TWO_ENGINE_RESET,
    CHANNEL_ONE_ENGINE_RESET, DRIVE_TRANSFER_FSM_RESET,
    CHANNEL_ONE_PIO_POLL_FSM_RESET, CHANNEL_TWO_PIO_POLL_FSM_RESET};
  wire [2:0] modes = {AUTOPOLL_TEST_ENABLE, LATENCY_TIMER_TEST_ENABLE,
    FIFO_TEST_ENABLE};
  idc_ctrl idc_ctrl_i (
    .CLK(CLK), .SRST(SRST), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
    .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
    .ACK_O(ACK_O), .IO_CYCLE_VALID(IO_CYCLE_VALID), .IO_ADDR(IO_ADDR),
    .BYTE_ENABLE_LANES_N(BYTE_ENABLE_LANES_N), .NATIVE_MODE(NATIVE_MODE),
    .SECOND_BASE_WINDOW_HIT(SECOND_BASE_WINDOW_HIT),
    .FOURTH_BASE_WINDOW_HIT(FOURTH_BASE_WINDOW_HIT),
    .ALT_FUNCTION_ENABLE(ALT_FUNCTION_ENABLE),
    .IDE_CYCLE_CLAIM(IDE_CYCLE_CLAIM), .FUNCTION_VISIBLE(FUNCTION_VISIBLE),
    .PROG_IF_READ_VALUE(PROG_IF_READ_VALUE),
    .WHOLE_DEVICE_RESET_PULSE(WHOLE_DEVICE_RESET_PULSE),
    .NONCONFIG_BLOCKS_RESET_PULSE(NONCONFIG_BLOCKS_RESET_PULSE),
    .CHANNEL_TWO_ENGINE_RESET(CHANNEL_TWO_ENGINE_RESET),
    .CHANNEL_ONE_ENGINE_RESET(CHANNEL_ONE_ENGINE_RESET),
    .DRIVE_TRANSFER_FSM_RESET(DRIVE_TRANSFER_FSM_RESET),
    .CHANNEL_ONE_PIO_POLL_FSM_RESET(CHANNEL_ONE_PIO_POLL_FSM_RESET),
    .CHANNEL_TWO_PIO_POLL_FSM_RESET(CHANNEL_TWO_PIO_POLL_FSM_RESET),
    .AUTOPOLL_TEST_ENABLE(AUTOPOLL_TEST_ENABLE),
    .LATENCY_TIMER_TEST_ENABLE(LATENCY_TIMER_TEST_ENABLE),
    .FIFO_TEST_ENABLE(FIFO_TEST_ENABLE));
  idc_io_host idc_io_host_i (.clk(CLK), .valid(IO_CYCLE_VALID),
    .addr(IO_ADDR), .be_n(BYTE_ENABLE_LANES_N));
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Classic single cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [11:0] a,
      input logic [7:0] d, input logic [3:0] sel);
    @(posedge CLK);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= we;
    ADR_I <= a;
    SEL_I <= sel;
    DAT_I <= {24'h0, d};
    do @(posedge CLK); while (ACK_O !== 1'b1);
    rdata = DAT_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
  endtask : wb
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00, 4'hf);
    chk("read data", {24'h0, e}, rdata);
  endtask : rd
  task automatic io(input logic [15:0] a, input logic [3:0] b,
      input logic e);
    idc_io_host_i.send(a, b);
    // Claim launched at the previous edge, read before this edge updates it
    @(posedge CLK);
    chk("claim", e, IDE_CYCLE_CLAIM);
  endtask : io
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    SRST = 1'b1;
    {CYC_I, STB_I, WE_I, ADR_I, SEL_I, DAT_I} = '0;
    {NATIVE_MODE, SECOND_BASE_WINDOW_HIT, FOURTH_BASE_WINDOW_HIT} = '0;
    ALT_FUNCTION_ENABLE = 1'b0;
    repeat (5) @(posedge CLK);
    SRST <= 1'b0;
    rd(12'h140, 8'h02);
    rd(12'h144, 8'h00);
    chk("modes", 3'h0, modes);
    chk("visible", 0, FUNCTION_VISIBLE);
    io(16'h03f6, 4'hb, 1'b0);
    wb(1'b1, 12'h140, 8'hff, 4'hf);
    rd(12'h140, 8'h2b);
    io(16'h03f6, 4'hf, 1'b0);
    io(16'h0376, 4'hb, 1'b1);
    NATIVE_MODE <= 1'b1;
    SECOND_BASE_WINDOW_HIT <= 1'b1;
    io(16'h0100, 4'hf, 1'b0);
    io(16'h0100, 4'hb, 1'b1);
    wb(1'b1, 12'h140, 8'h03, 4'hf);
    {SECOND_BASE_WINDOW_HIT, FOURTH_BASE_WINDOW_HIT} <= 2'b01;
    io(16'h0100, 4'hf, 1'b1);
    io(16'h03f6, 4'hf, 1'b1);
    wb(1'b1, 12'h024, 8'h70, 4'hf);
    rd(12'h024, 8'h70);
    chk("prog if", 3'h7, PROG_IF_READ_VALUE);
    wb(1'b1, 12'h140, 8'h01, 4'hf);
    rd(12'h024, 8'h00);
    chk("prog if", 3'h0, PROG_IF_READ_VALUE);
    wb(1'b1, 12'h140, 8'h03, 4'hf);
    wb(1'b1, 12'h144, 8'h07, 4'he);
    rd(12'h144, 8'h00);
    rd(12'h200, 8'h00);
    wb(1'b1, 12'h144, 8'h0f, 4'hf);
    rd(12'h144, 8'h07);
    chk("modes", 3'h7, {AUTOPOLL_TEST_ENABLE, LATENCY_TIMER_TEST_ENABLE,
      FIFO_TEST_ENABLE});
    wb(1'b1, 12'h144, 8'h02, 4'hf);
    rd(12'h144, 8'h02);
    chk("modes", 3'h2, modes);
    wb(1'b1, 12'h144, 8'h04, 4'hf);
    rd(12'h144, 8'h04);
    chk("modes", 3'h4, modes);
    for (int i = 4; i < 8; i++) begin
      exp_p = {i == 7, i == 6, i == 5, i == 4, 1'b1, i != 5, i != 4};
      wb(1'b1, 12'h144, 8'h07 | (8'h01 << i), 4'hf);
      #1;
      chk("pulses", exp_p, pulses);
      @(posedge CLK);
      #1;
      chk("pulses low", 7'h00, pulses);
      if (i == 6) rd(12'h140, 8'h03);
    end
    rd(12'h144, 8'h00);
    chk("modes", 3'h0, modes);
    rd(12'h140, 8'h02);
    rd(12'h024, 8'h00);
    ALT_FUNCTION_ENABLE <= 1'b1;
    @(posedge CLK);
    io(16'h03f6, 4'hf, 1'b1);
    chk("visible", 1, FUNCTION_VISIBLE);
    finish_test();
  end
endmodule : test_ide_decode_and_reset_control
`default_nettype wire
